// File: rtl/status_led_defines.svh
`ifndef STATUS_LED_DEFINES_SVH
`define STATUS_LED_DEFINES_SVH
// Register byte offsets
`define LED_CTRL_OFF 12'h000
`define LED_STATE_OFF 12'h004
`define LED_ERR_OFF 12'h008
`define LED_IRQ_STAT_OFF 12'h00c
`define LED_IRQ_MASK_OFF 12'h010
`define LED_OUT_OFF 12'h014
// Control field positions
`define CTRL_RUNNING_BIT 0
`define CTRL_BOOT_BIT 1
`define CTRL_FWDL_BIT 2
`define CTRL_BOOTSTRAP_BIT 3
// Error request field positions
`define ERR_CFG_BIT 0
`define ERR_LOCAL_BIT 1
`define ERR_WDOG_BIT 2
// Reset values
`define CTRL_RESET 4'h0
`define MASK_RESET 4'h0
// Pattern timing in ticks of TICK_CYCLES clocks (1 us each at CLK_KHZ)
`define FLICKER_MS 50
`define BLINK_MS 200
`define FLASH_MS 200
`define FLASH_OFF_MS 1000
// Clock rate in kHz
`define CLK_KHZ 100000
`define TICK_CYCLES (`CLK_KHZ / 1000)
`endif

// File: rtl/status_led_pkg.sv
`default_nettype none
package status_led_pkg;
   // Application-layer slave state codes
   typedef enum logic [3:0] {
      al_init_type_v = 4'h1,
      al_preop_type_v = 4'h2,
      al_boot_type_v = 4'h3,
      al_safeop_type_v = 4'h4,
      al_op_type_v = 4'h8
   } al_state_type;
   // Error pattern selection, one-hot
   typedef enum logic [3:0] {
      err_none = 4'b0001,
      err_cfg = 4'b0010,
      err_local = 4'b0100,
      err_wdog = 4'b1000
   } err_sel_type;
endpackage
`default_nettype wire

// File: rtl/fieldbus_status_led_driver.sv
// Notes on behaviour
// - Power LED dark in reset, lit running
// - Link LED: off, on, flicker on traffic
// - Run LED dark in INIT
// - Run LED blinks in PRE-OPERATIONAL
// - Run LED single-flashes in SAFE-OPERATIONAL
// - Run LED steady in OPERATIONAL
// - Run LED flickers booting, bootstrap, download
// - Error LED dark without error
// - Error LED blinks on invalid configuration
// - Error LED single-flashes on local error
// - Health LED dark when unpowered
// - Health LED blinks green when normal
// - Health LED blinks orange when abnormal
// - Bad or mismatched module means abnormal
`include "status_led_defines.svh"
`default_nettype none
module fieldbus_status_led_driver #(
   parameter int PORTS = 2,
   parameter int MODULES = 4,
   parameter int TICK_CYC = `TICK_CYCLES,
   parameter int FLICKER_TICKS = `FLICKER_MS,
   parameter int BLINK_TICKS = `BLINK_MS,
   parameter int FLASH_TICKS = `FLASH_MS,
   parameter int FLASH_OFF_TICKS = `FLASH_OFF_MS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Network ports
   input wire logic [PORTS-1:0] port_link,
   input wire logic [PORTS-1:0] port_traffic,
   // I/O module health
   input wire logic [MODULES-1:0] module_fault,
   input wire logic [MODULES-1:0] module_mismatch,
   // Interrupt
   output logic irq,
   // LEDs
   output logic power_led,
   output logic [PORTS-1:0] link_led,
   output logic run_led,
   output logic err_led,
   output logic system_health_indicator_green,
   output logic system_health_indicator_orange
);
   // Software registers
   logic [3:0] ctrl_ff;
   logic [3:0] al_state_ff;
   logic [2:0] err_req_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   // Pattern timing
   logic [15:0] tick_cnt_ff;
   logic tick;
   logic [15:0] flk_cnt_ff;
   logic flicker_ph_ff;
   logic [15:0] blk_cnt_ff;
   logic blink_ph_ff;
   logic [15:0] fl_cnt_ff;
   logic [1:0] fl_step_ff;
   logic single_ph_ff;
   logic double_ph_ff;
   // Error selection
   status_led_pkg::err_sel_type err_sel_ff;
   status_led_pkg::err_sel_type nxt_err_sel;
   logic [2:0] err_req_d_ff;
   logic [2:0] err_rise;
   // Health and link edge detection
   logic abnormal;
   logic abnormal_d_ff;
   logic [PORTS-1:0] link_d_ff;
   logic running;
   // Bus strobes
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [3:0] irq_event;

   // APB decode, zero wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr == `LED_CTRL_OFF) || (paddr == `LED_STATE_OFF) ||
      (paddr == `LED_ERR_OFF) || (paddr == `LED_IRQ_STAT_OFF) ||
      (paddr == `LED_IRQ_MASK_OFF) || (paddr == `LED_OUT_OFF);
   assign pslverr = psel && penable && !addr_ok;
   assign running = ctrl_ff[`CTRL_RUNNING_BIT];

   // Control register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `CTRL_RESET;
      end else if (wr_en && paddr == `LED_CTRL_OFF) begin
         ctrl_ff <= pwdata[3:0];
      end
   end

   // Application-layer state write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         al_state_ff <= status_led_pkg::al_init_type_v;
      end else if (wr_en && paddr == `LED_STATE_OFF) begin
         al_state_ff <= pwdata[3:0];
      end
   end

   // Error request write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_req_ff <= 3'h0;
      end else if (wr_en && paddr == `LED_ERR_OFF) begin
         err_req_ff <= pwdata[2:0];
      end
   end

   // Interrupt mask write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= `MASK_RESET;
      end else if (wr_en && paddr == `LED_IRQ_MASK_OFF) begin
         irq_mask_ff <= pwdata[3:0];
      end
   end

   // Events: link up, abnormal entry, watchdog rise, config error rise
   assign irq_event = {err_rise[`ERR_CFG_BIT], err_rise[`ERR_WDOG_BIT],
      abnormal && !abnormal_d_ff, |(port_link & ~link_d_ff)};

   // Sticky status, read clears, new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= 4'h0;
      end else if (rd_en && paddr == `LED_IRQ_STAT_OFF) begin
         irq_stat_ff <= irq_event;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_event;
      end
   end

   // Interrupt level output
   assign irq = |(irq_stat_ff & irq_mask_ff);

   // Read data mux, registered view of state
   always_comb begin
      prdata = 32'h0;
      unique case (paddr)
         `LED_CTRL_OFF: prdata = {28'h0, ctrl_ff};
         `LED_STATE_OFF: prdata = {28'h0, al_state_ff};
         `LED_ERR_OFF: prdata = {29'h0, err_req_ff};
         `LED_IRQ_STAT_OFF: prdata = {28'h0, irq_stat_ff};
         `LED_IRQ_MASK_OFF: prdata = {28'h0, irq_mask_ff};
         `LED_OUT_OFF: prdata = {24'h0, system_health_indicator_orange,
            system_health_indicator_green, err_led, run_led,
            {(4-PORTS){1'b0}}, link_led};
         default: prdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_ff <= 16'h0;
      end else if (tick_cnt_ff == 16'(TICK_CYC - 1)) begin
         tick_cnt_ff <= 16'h0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 16'h1;
      end
   end
   assign tick = (tick_cnt_ff == 16'(TICK_CYC - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flk_cnt_ff <= 16'h0;
         flicker_ph_ff <= 1'b0;
      end else if (tick) begin
         if (flk_cnt_ff == 16'(FLICKER_TICKS - 1)) begin
            flk_cnt_ff <= 16'h0;
            flicker_ph_ff <= !flicker_ph_ff;
         end else begin
            flk_cnt_ff <= flk_cnt_ff + 16'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_cnt_ff <= 16'h0;
         blink_ph_ff <= 1'b0;
      end else if (tick) begin
         if (blk_cnt_ff == 16'(BLINK_TICKS - 1)) begin
            blk_cnt_ff <= 16'h0;
            blink_ph_ff <= !blink_ph_ff;
         end else begin
            blk_cnt_ff <= blk_cnt_ff + 16'h1;
         end
      end
   end

   // Flash sequencer: on, off, on, long off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_cnt_ff <= 16'h0;
         fl_step_ff <= 2'h0;
      end else if (tick) begin
         if ((fl_step_ff != 2'h3 && fl_cnt_ff == 16'(FLASH_TICKS - 1)) ||
            (fl_step_ff == 2'h3 && fl_cnt_ff == 16'(FLASH_OFF_TICKS - 1)))
            begin
            fl_cnt_ff <= 16'h0;
            fl_step_ff <= fl_step_ff + 2'h1;
         end else begin
            fl_cnt_ff <= fl_cnt_ff + 16'h1;
         end
      end
   end

   // Flash outputs from the step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_ph_ff <= 1'b0;
         double_ph_ff <= 1'b0;
      end else begin
         single_ph_ff <= (fl_step_ff == 2'h0);
         double_ph_ff <= (fl_step_ff == 2'h0) || (fl_step_ff == 2'h2);
      end
   end

   // Module fault or mismatch is abnormal
   assign abnormal = |module_fault || |module_mismatch;

   // Edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abnormal_d_ff <= 1'b0;
         link_d_ff <= '0;
         err_req_d_ff <= 3'h0;
      end else begin
         abnormal_d_ff <= abnormal;
         link_d_ff <= port_link;
         err_req_d_ff <= err_req_ff;
      end
   end
   assign err_rise = err_req_ff & ~err_req_d_ff;

   // Newest error wins, fall back when it clears
   always_comb begin
      nxt_err_sel = err_sel_ff;
      if (err_rise[`ERR_WDOG_BIT]) begin
         nxt_err_sel = status_led_pkg::err_wdog;
      end else if (err_rise[`ERR_LOCAL_BIT]) begin
         nxt_err_sel = status_led_pkg::err_local;
      end else if (err_rise[`ERR_CFG_BIT]) begin
         nxt_err_sel = status_led_pkg::err_cfg;
      end else begin
         unique case (err_sel_ff)
            status_led_pkg::err_none: nxt_err_sel = status_led_pkg::err_none;
            status_led_pkg::err_cfg:
               if (!err_req_ff[`ERR_CFG_BIT]) nxt_err_sel = status_led_pkg::err_none;
            status_led_pkg::err_local:
               if (!err_req_ff[`ERR_LOCAL_BIT]) nxt_err_sel = status_led_pkg::err_none;
            status_led_pkg::err_wdog:
               if (!err_req_ff[`ERR_WDOG_BIT]) nxt_err_sel = status_led_pkg::err_none;
         endcase
         // Another still-active condition takes over
         if (nxt_err_sel == status_led_pkg::err_none) begin
            if (err_req_ff[`ERR_WDOG_BIT])
               nxt_err_sel = status_led_pkg::err_wdog;
            else if (err_req_ff[`ERR_LOCAL_BIT])
               nxt_err_sel = status_led_pkg::err_local;
            else if (err_req_ff[`ERR_CFG_BIT])
               nxt_err_sel = status_led_pkg::err_cfg;
         end
      end
   end

   // Error selection register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_sel_ff <= status_led_pkg::err_none;
      end else begin
         err_sel_ff <= nxt_err_sel;
      end
   end

   // Power LED
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_led <= 1'b0;
      end else begin
         power_led <= running;
      end
   end

   // Link LEDs, one per port
   genvar gi;
   generate
      for (gi = 0; gi < PORTS; gi++) begin : g_link
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               link_led[gi] <= 1'b0;
            end else begin
               link_led[gi] <= port_link[gi] &&
                  (!port_traffic[gi] || flicker_ph_ff);
            end
         end
      end
   endgenerate

   // Run LED
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_led <= 1'b0;
      end else if (ctrl_ff[`CTRL_BOOT_BIT] || ctrl_ff[`CTRL_FWDL_BIT] ||
         ctrl_ff[`CTRL_BOOTSTRAP_BIT] ||
         al_state_ff == status_led_pkg::al_boot_type_v) begin
         run_led <= flicker_ph_ff;
      end else begin
         unique case (al_state_ff)
            status_led_pkg::al_preop_type_v: run_led <= blink_ph_ff;
            status_led_pkg::al_safeop_type_v: run_led <= single_ph_ff;
            status_led_pkg::al_op_type_v: run_led <= 1'b1;
            default: run_led <= 1'b0;
         endcase
      end
   end

   // Error LED
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_led <= 1'b0;
      end else begin
         unique case (err_sel_ff)
            status_led_pkg::err_none: err_led <= 1'b0;
            status_led_pkg::err_cfg: err_led <= blink_ph_ff;
            status_led_pkg::err_local: err_led <= single_ph_ff;
            status_led_pkg::err_wdog: err_led <= double_ph_ff;
         endcase
      end
   end

   // Health indicator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_health_indicator_green <= 1'b0;
         system_health_indicator_orange <= 1'b0;
      end else begin
         system_health_indicator_green <= running && !abnormal && blink_ph_ff;
         system_health_indicator_orange <= running && abnormal && blink_ph_ff;
      end
   end
endmodule // fieldbus_status_led_driver
`default_nettype wire

// File: bench/led_panel_observer.sv
`default_nettype none
// Watches one front-panel lamp the way an operator would
module led_panel_observer (
   // Clock and control
   input wire logic clk,
   input wire logic clr,
   // Lamp under watch
   input wire logic led,
   // Lit cycles and turn-on count since last clear
   output int hi,
   output int rises
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_ff; // Lamp level one cycle back
   // Count lit cycles and rising edges over a window
   always_ff @(posedge clk) begin
      if (clr) begin
         hi <= 0;
         rises <= 0;
      end else begin
         hi <= hi + int'(led);
         rises <= rises + int'(led && !prev_ff);
      end
      prev_ff <= led;
   end
endmodule // led_panel_observer
`default_nettype wire

// File: bench/status_led_props.sv
`default_nettype none
// Port-level checks on the lamp driver
module status_led_props #(
   parameter int PORTS = 2,
   parameter int MODULES = 4
) (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Status inputs
   input wire logic [PORTS-1:0] port_link,
   input wire logic [PORTS-1:0] port_traffic,
   input wire logic [MODULES-1:0] module_fault,
   input wire logic [MODULES-1:0] module_mismatch,
   // Lamps
   input wire logic power_led,
   input wire logic [PORTS-1:0] link_led,
   input wire logic run_led,
   input wire logic err_led,
   input wire logic system_health_indicator_green,
   input wire logic system_health_indicator_orange
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr; // Write taken this edge
   logic bad; // Any module abnormal
   logic [3:0] ctrl_ff; // Shadow of the control word
   assign wr = psel && penable && pwrite;
   assign bad = (|module_fault) || (|module_mismatch);
   // Track control bits written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= 4'h0;
      end else if (wr && paddr == 12'h000) begin
         ctrl_ff <= pwdata[3:0];
      end
   end
   // Control write with running set or clear
   sequence s_run_on;
      wr && paddr == 12'h000 && pwdata[0];
   endsequence
   sequence s_run_off;
      wr && paddr == 12'h000 && !pwdata[0];
   endsequence
   property p_pwr_on;
      s_run_on |-> ##2 power_led;
   endproperty
   a_pwr_on: assert property (p_pwr_on)
      else $error("power lamp not lit after running set");
   property p_pwr_off;
      s_run_off |-> ##2 !power_led;
   endproperty
   a_pwr_off: assert property (p_pwr_off)
      else $error("power lamp lit while not running");
   property p_link_off;
      !port_link[0] |=> !link_led[0];
   endproperty
   a_link_off: assert property (p_link_off)
      else $error("link lamp lit without link");
   property p_link_on;
      port_link[0] && !port_traffic[0] |=> link_led[0];
   endproperty
   a_link_on: assert property (p_link_on)
      else $error("idle link lamp not steady");
   property p_run_init;
      wr && paddr == 12'h004 && pwdata[3:0] == 4'h1 && ctrl_ff[3:1] == 3'h0
         |-> ##2 !run_led;
   endproperty
   a_run_init: assert property (p_run_init)
      else $error("run lamp lit in init");
   property p_err_clr;
      wr && paddr == 12'h008 && pwdata[2:0] == 3'h0 |-> ##3 !err_led;
   endproperty
   a_err_clr: assert property (p_err_clr)
      else $error("error lamp lit after all errors cleared");
   property p_hlth_norm;
      !bad |=> !system_health_indicator_orange;
   endproperty
   a_hlth_norm: assert property (p_hlth_norm)
      else $error("orange lamp while healthy");
   property p_hlth_abn;
      bad |=> !system_health_indicator_green;
   endproperty
   a_hlth_abn: assert property (p_hlth_abn)
      else $error("green lamp while module abnormal");
   property p_unmapped;
      psel && penable && paddr > 12'h014 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
endmodule // status_led_props
bind fieldbus_status_led_driver status_led_props #(
   .PORTS(PORTS), .MODULES(MODULES)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .port_link(port_link), .port_traffic(port_traffic),
   .module_fault(module_fault), .module_mismatch(module_mismatch),
   .power_led(power_led), .link_led(link_led), .run_led(run_led),
   .err_led(err_led),
   .system_health_indicator_green(system_health_indicator_green),
   .system_health_indicator_orange(system_health_indicator_orange));
`default_nettype wire

// File: bench/fieldbus_status_led_driver_test.sv
`default_nettype none
module fieldbus_status_led_driver_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Lamp selectors and pattern kinds
   localparam int LNK = 0, RUN = 1, ERR = 2, GRN = 3, ORG = 4;
   localparam int OFF = 0, ON = 1, BLK = 2, SGL = 3, DBL = 4, FLK = 5;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic power_led, run_led, err_led, grn, org, clr, rd_e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_d;
   logic [1:0] port_link, port_traffic, link_led;
   logic [3:0] module_fault, module_mismatch;
   logic [4:0] obs; // Lamps handed to the observers
   int hi_a [5];
   int ri_a [5];
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   assign obs = {org, grn, err_led, run_led, link_led[0]};
   // Short pattern timing keeps windows at 120 cycles
   fieldbus_status_led_driver #(.TICK_CYC(2), .FLICKER_TICKS(2),
      .BLINK_TICKS(3), .FLASH_TICKS(2), .FLASH_OFF_TICKS(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_link(port_link),
      .port_traffic(port_traffic), .module_fault(module_fault),
      .module_mismatch(module_mismatch), .irq(irq), .power_led(power_led),
      .link_led(link_led), .run_led(run_led), .err_led(err_led),
      .system_health_indicator_green(grn),
      .system_health_indicator_orange(org));
   for (genvar i = 0; i < 5; i++) begin : g_obs
      led_panel_observer u_obs (.clk(pclk), .clr(clr), .led(obs[i]),
         .hi(hi_a[i]), .rises(ri_a[i]));
   end
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // One bus transfer; waits for pready in the access phase
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends on the first edge that sees pready high
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_d = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Classify a lamp by lit cycles and turn-ons in 120 cycles
   function automatic int kind(input int hi, input int r);
      if (hi == 0) return OFF;
      if (hi == 120) return ON;
      if (hi < 36) return SGL;
      if (hi < 54) return DBL;
      if (r >= 13) return FLK;
      return BLK;
   endfunction
   task automatic exp(input int s, input int k, input string m);
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (120) @(posedge pclk);
      #1;
      chk(kind(hi_a[s], ri_a[s]) == k, m);
      // Return on an edge so the next stimulus lands on it
      @(posedge pclk);
   endtask
   task automatic t_power;
      apb(1, 12'h000, 32'h1);
      repeat (3) @(posedge pclk);
      chk(power_led === 1'b1, "power lamp dark while running");
      apb(1, 12'h000, 32'h0);
      repeat (3) @(posedge pclk);
      chk(power_led === 1'b0, "power lamp lit while stopped");
      $display("power test done");
   endtask
   task automatic t_link;
      port_link <= 2'b01;
      exp(LNK, ON, "idle link lamp");
      port_traffic <= 2'b01;
      exp(LNK, FLK, "busy link lamp");
      port_link <= 2'b00;
      exp(LNK, OFF, "no link lamp");
      port_traffic <= 2'b00;
      $display("link test done");
   endtask
   // Control word, slave state and expected run pattern
   task automatic t_run;
      logic [3:0] c [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h5, 4'h9};
      logic [3:0] s [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h1, 4'h1, 4'h8};
      int k [8] = '{OFF, BLK, SGL, ON, FLK, FLK, FLK, FLK};
      for (int i = 0; i < 8; i++) begin
         apb(1, 12'h000, {28'h0, c[i]});
         apb(1, 12'h004, {28'h0, s[i]});
         exp(RUN, k[i], "run lamp pattern");
      end
      $display("run test done");
   endtask
   task automatic t_err;
      apb(1, 12'h000, 32'h1);
      exp(ERR, OFF, "error lamp without error");
      apb(1, 12'h008, 32'h1);
      exp(ERR, BLK, "config error lamp");
      apb(1, 12'h008, 32'h5);
      exp(ERR, DBL, "newest is watchdog");
      apb(1, 12'h008, 32'h7);
      exp(ERR, SGL, "newest is local error");
      apb(1, 12'h008, 32'h5);
      exp(ERR, DBL, "falls back to watchdog");
      apb(1, 12'h008, 32'h0);
      exp(ERR, OFF, "all errors cleared");
      $display("error test done");
   endtask
   task automatic t_health;
      exp(GRN, BLK, "green blink when healthy");
      exp(ORG, OFF, "no orange when healthy");
      module_mismatch <= 4'h2;
      exp(ORG, BLK, "orange on mismatch");
      exp(GRN, OFF, "green off on mismatch");
      module_mismatch <= 4'h0;
      module_fault <= 4'h8;
      exp(ORG, BLK, "orange on faulty module");
      module_fault <= 4'h0;
      apb(1, 12'h000, 32'h0);
      exp(GRN, OFF, "health lamp dark unpowered");
      $display("health test done");
   endtask
   // Masked link event, read-to-clear, unmapped access
   task automatic t_irq;
      apb(1, 12'h010, 32'h1);
      apb(0, 12'h010, 32'h0);
      chk(rd_d === 32'h1, "mask read back");
      apb(0, 12'h00c, 32'h0);
      port_link <= 2'b10;
      repeat (3) @(posedge pclk);
      chk(irq === 1'b1, "irq after link event");
      chk(link_led === 2'b10, "second port link lamp");
      // Lamp view: run steady in operational, second link lit
      apb(0, 12'h014, 32'h0);
      chk(rd_d === 32'h12, "lamp view read back");
      apb(0, 12'h00c, 32'h0);
      chk(rd_d[0] === 1'b1, "link status bit");
      repeat (2) @(posedge pclk);
      chk(irq === 1'b0, "irq after status read");
      apb(1, 12'h010, 32'h0);
      port_link <= 2'b00;
      @(posedge pclk);
      port_link <= 2'b01;
      repeat (3) @(posedge pclk);
      chk(irq === 1'b0, "masked irq stays low");
      apb(0, 12'h00c, 32'h0);
      chk(rd_d[0] === 1'b1, "masked event still latched");
      apb(0, 12'h020, 32'h0);
      chk(rd_e === 1'b1 && rd_d === 32'h0, "unmapped read refused");
      $display("irq test done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, clr} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {port_link, port_traffic} = 4'h0;
      {module_fault, module_mismatch} = 8'h00;
      repeat (20) @(posedge pclk);
      chk(power_led === 1'b0, "power lamp lit in reset");
      presetn <= 1'b1;
      t_power();
      t_link();
      t_run();
      t_err();
      t_health();
      t_irq();
      complete_run();
   end
endmodule // fieldbus_status_led_driver_test
`default_nettype wire
